// ===== src/ipr_pkg.sv
// Overview of operation
// - Field value is the priority level, 7 highest.
// - Fields are read/write and reset to 100.
// - Unimplemented bits always read as zero.
// - Register 2 holds serial1 rx, spi event/error, timer3.
// - Register 3 holds dma1, adc1, serial1 tx.
// - Register 4 holds change notify, i2c master/slave.
// - Register 5 holds capture 8/7, adc2, ext irq1.
// - Register 6 holds timer4, compare 4/3, dma2.
// - Register 7 holds serial2 tx/rx, ext irq2, timer5.
package ipr_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int        IPR_NUM_REGS   = 6;
  localparam logic [4:0] IPR_OFS_CTRL_2 = 5'h00;
  localparam logic [4:0] IPR_OFS_CTRL_3 = 5'h04;
  localparam logic [4:0] IPR_OFS_CTRL_4 = 5'h08;
  localparam logic [4:0] IPR_OFS_CTRL_5 = 5'h0c;
  localparam logic [4:0] IPR_OFS_CTRL_6 = 5'h10;
  localparam logic [4:0] IPR_OFS_CTRL_7 = 5'h14;

  // ----------------------------------------------------------------
  // Field layout
  // ----------------------------------------------------------------
  localparam logic [15:0] IPR_FIELD_RESET = 16'h4444;
  localparam logic [15:0] IPR_MASK_FULL   = 16'h7777;
  localparam logic [15:0] IPR_MASK_CTRL_3 = 16'h0777;
  localparam logic [15:0] IPR_MASK_CTRL_4 = 16'h7077;
  localparam logic [2:0]  IPR_LEVEL_OFF   = 3'h0;

  // ----------------------------------------------------------------
  // AHB-Lite encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] IPR_HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] IPR_HTRANS_SEQ    = 2'h3;
  localparam logic       IPR_HRESP_OKAY    = 1'b0;

endpackage

// ===== src/ipr_regs.sv
`timescale 1ns/1ps
module ipr_regs
  import ipr_pkg::*;
(
  // Clock and reset.
  input  wire logic        core_clk_in,
  input  wire logic        rst_in,
  // AHB-Lite slave.
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic        hready_in,
  output logic      [31:0] hrdata_out,
  output logic             hreadyout_out,
  output logic             hresp_out,
  // Priority levels towards arbitration, zero means disabled.
  output logic      [2:0]  serial1_rx_level_out,
  output logic      [2:0]  spi_one_event_level_out,
  output logic      [2:0]  spi_one_error_level_out,
  output logic      [2:0]  timer_three_level_out,
  output logic      [2:0]  dma_ch1_done_level_out,
  output logic      [2:0]  adc_one_done_level_out,
  output logic      [2:0]  serial1_tx_level_out,
  output logic      [2:0]  change_notify_level_out,
  output logic      [2:0]  i2c_one_master_level_out,
  output logic      [2:0]  i2c_one_slave_level_out,
  output logic      [2:0]  capture_ch8_level_out,
  output logic      [2:0]  capture_ch7_level_out,
  output logic      [2:0]  adc_two_done_level_out,
  output logic      [2:0]  ext_irq1_level_out,
  output logic      [2:0]  timer_four_level_out,
  output logic      [2:0]  compare_ch4_level_out,
  output logic      [2:0]  compare_ch3_level_out,
  output logic      [2:0]  dma_ch2_done_level_out,
  output logic      [2:0]  serial2_tx_level_out,
  output logic      [2:0]  serial2_rx_level_out,
  output logic      [2:0]  ext_irq2_level_out,
  output logic      [2:0]  timer_five_level_out,
  // Per-source enable, low when the level is zero.
  output logic      [21:0] source_enable_out
);

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  // Implemented bits per register, in register order 2 to 7.
  localparam logic [15:0] IMPL_MASK [IPR_NUM_REGS] = '{
    IPR_MASK_FULL,
    IPR_MASK_CTRL_3,
    IPR_MASK_CTRL_4,
    IPR_MASK_FULL,
    IPR_MASK_FULL,
    IPR_MASK_FULL
  };

  // ----------------------------------------------------------------
  // Source map
  // ----------------------------------------------------------------
  // Each source is listed once, in the bit order of the enable port.
  // The table names the register that holds its level and the lowest
  // bit of its field, so the enable logic is a single loop; the level
  // port slices are written out by hand rather than read from the table, and match it.
  localparam int NUM_SOURCES = 22;
  localparam int FIELD_WIDTH = 3;

  localparam int SRC_REG [NUM_SOURCES] = '{
    0, // Serial 1 receive.
    0, // SPI event.
    0, // SPI error.
    0, // Timer 3.
    1, // DMA channel 1 done.
    1, // ADC 1 done.
    1, // Serial 1 transmit.
    2, // Change notification.
    2, // I2C master events.
    2, // I2C slave events.
    3, // Capture channel 8.
    3, // Capture channel 7.
    3, // ADC 2 done.
    3, // External interrupt 1.
    4, // Timer 4.
    4, // Compare channel 4.
    4, // Compare channel 3.
    4, // DMA channel 2 done.
    5, // Serial 2 transmit.
    5, // Serial 2 receive.
    5, // External interrupt 2.
    5  // Timer 5.
  };

  localparam int SRC_POS [NUM_SOURCES] = '{
    12, // Serial 1 receive.
    8,  // SPI event.
    4,  // SPI error.
    0,  // Timer 3.
    8,  // DMA channel 1 done.
    4,  // ADC 1 done.
    0,  // Serial 1 transmit.
    12, // Change notification.
    4,  // I2C master events.
    0,  // I2C slave events.
    12, // Capture channel 8.
    8,  // Capture channel 7.
    4,  // ADC 2 done.
    0,  // External interrupt 1.
    12, // Timer 4.
    8,  // Compare channel 4.
    4,  // Compare channel 3.
    0,  // DMA channel 2 done.
    12, // Serial 2 transmit.
    8,  // Serial 2 receive.
    4,  // External interrupt 2.
    0   // Timer 5.
  };

  logic [15:0] priority_ctrl [IPR_NUM_REGS];
  logic        wr_pend;
  logic        wr_hit;
  logic [2:0]  wr_idx;
  logic [2:0]  addr_idx;
  logic        addr_hit;
  logic        take;
  logic [15:0] next_ctrl [IPR_NUM_REGS];
  logic [IPR_NUM_REGS-1:0] wr_strobe;
  logic [NUM_SOURCES-1:0]  next_enable;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  always_comb begin
    addr_idx = 3'h0;
    addr_hit = 1'b0;
    case (haddr_in[4:0])
      IPR_OFS_CTRL_2: begin
        addr_idx = 3'h0;
        addr_hit = 1'b1;
      end
      IPR_OFS_CTRL_3: begin
        addr_idx = 3'h1;
        addr_hit = 1'b1;
      end
      IPR_OFS_CTRL_4: begin
        addr_idx = 3'h2;
        addr_hit = 1'b1;
      end
      IPR_OFS_CTRL_5: begin
        addr_idx = 3'h3;
        addr_hit = 1'b1;
      end
      IPR_OFS_CTRL_6: begin
        addr_idx = 3'h4;
        addr_hit = 1'b1;
      end
      IPR_OFS_CTRL_7: begin
        addr_idx = 3'h5;
        addr_hit = 1'b1;
      end
      default: begin
        addr_idx = 3'h0;
        addr_hit = 1'b0;
      end
    endcase
    if (haddr_in[31:5] != 27'h0) begin
      addr_hit = 1'b0;
    end
  end

  assign take = hsel_in && hready_in &&
                (htrans_in == IPR_HTRANS_NONSEQ ||
                 htrans_in == IPR_HTRANS_SEQ);

  // ----------------------------------------------------------------
  // Bus phases
  // ----------------------------------------------------------------
  // Writes are captured in the address phase and committed in the data
  // phase; every transfer completes with zero wait states.
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      wr_pend <= 1'b0;
      wr_hit  <= 1'b0;
      wr_idx  <= 3'h0;
    end else begin
      wr_pend <= take && hwrite_in;
      wr_hit  <= addr_hit;
      wr_idx  <= addr_idx;
    end
  end

  // Unmapped addresses read zero and drop writes, still answering OKAY.
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      hrdata_out <= 32'h0;
    end else if (take && !hwrite_in && addr_hit) begin
      hrdata_out <= {16'h0, priority_ctrl[addr_idx] & IMPL_MASK[addr_idx]};
    end else if (take) begin
      hrdata_out <= 32'h0;
    end
  end

  // The bank never stalls, so the master sees one-cycle data phases.
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      hreadyout_out <= 1'b1;
    end else begin
      hreadyout_out <= 1'b1;
    end
  end

  // No address is refused, so the answer is always OKAY.
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      hresp_out <= IPR_HRESP_OKAY;
    end else begin
      hresp_out <= IPR_HRESP_OKAY;
    end
  end

  // ----------------------------------------------------------------
  // Priority registers
  // ----------------------------------------------------------------
  // The next value of each register is formed once and feeds both the
  // register and the enable flops, so levels and enables move together.
  generate
    for (genvar r = 0; r < IPR_NUM_REGS; r++) begin : g_reg
      assign wr_strobe[r] = wr_pend && wr_hit && wr_idx == 3'(r);

      always_comb begin
        next_ctrl[r] = priority_ctrl[r];
        if (wr_strobe[r]) begin
          next_ctrl[r] = hwdata_in[15:0] & IMPL_MASK[r];
        end
      end

      always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
          priority_ctrl[r] <= IPR_FIELD_RESET & IMPL_MASK[r];
        end else begin
          priority_ctrl[r] <= next_ctrl[r];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Level outputs
  // ----------------------------------------------------------------
  // The register bits drive the level ports directly, so a write shows
  // at arbitration on the edge that ends its data phase.
  assign serial1_rx_level_out     = priority_ctrl[0][14:12];
  assign spi_one_event_level_out  = priority_ctrl[0][10:8];
  assign spi_one_error_level_out  = priority_ctrl[0][6:4];
  assign timer_three_level_out    = priority_ctrl[0][2:0];
  assign dma_ch1_done_level_out   = priority_ctrl[1][10:8];
  assign adc_one_done_level_out   = priority_ctrl[1][6:4];
  assign serial1_tx_level_out     = priority_ctrl[1][2:0];
  assign change_notify_level_out  = priority_ctrl[2][14:12];
  assign i2c_one_master_level_out = priority_ctrl[2][6:4];
  assign i2c_one_slave_level_out  = priority_ctrl[2][2:0];
  assign capture_ch8_level_out    = priority_ctrl[3][14:12];
  assign capture_ch7_level_out    = priority_ctrl[3][10:8];
  assign adc_two_done_level_out   = priority_ctrl[3][6:4];
  assign ext_irq1_level_out       = priority_ctrl[3][2:0];
  assign timer_four_level_out     = priority_ctrl[4][14:12];
  assign compare_ch4_level_out    = priority_ctrl[4][10:8];
  assign compare_ch3_level_out    = priority_ctrl[4][6:4];
  assign dma_ch2_done_level_out   = priority_ctrl[4][2:0];
  assign serial2_tx_level_out     = priority_ctrl[5][14:12];
  assign serial2_rx_level_out     = priority_ctrl[5][10:8];
  assign ext_irq2_level_out       = priority_ctrl[5][6:4];
  assign timer_five_level_out     = priority_ctrl[5][2:0];

  // ----------------------------------------------------------------
  // Source enables
  // ----------------------------------------------------------------
  // Levels are plain binary, so arbitration compares them as numbers;
  // only level zero needs a flag of its own. The enables are taken
  // from the next register values so the flops agree with the level
  // ports on every cycle, reset included.
  generate
    for (genvar s = 0; s < NUM_SOURCES; s++) begin : g_en
      assign next_enable[s] =
        next_ctrl[SRC_REG[s]][SRC_POS[s] +: FIELD_WIDTH]
          != IPR_LEVEL_OFF;
    end
  endgenerate

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      for (int s = 0; s < NUM_SOURCES; s++) begin
        source_enable_out[s] <=
          IPR_FIELD_RESET[SRC_POS[s] +: FIELD_WIDTH] != IPR_LEVEL_OFF;
      end
    end else begin
      source_enable_out <= next_enable;
    end
  end

endmodule

// ===== dv/ipr_regs_properties.sv
`timescale 1ns/1ps
module ipr_regs_checker (
  // Clock, reset and bus.
  input wire logic        core_clk_in, rst_in, hsel_in, hwrite_in,
  input wire logic        hready_in, hreadyout_out, hresp_out,
  input wire logic [1:0]  htrans_in,
  input wire logic [31:0] haddr_in, hwdata_in, hrdata_out,
  // Priority levels and enables.
  input wire logic [2:0]  serial1_rx_level_out, timer_three_level_out,
  input wire logic [2:0]  timer_five_level_out,
  input wire logic [21:0] source_enable_out
);
  wire take = hsel_in && hready_in && htrans_in[1];
  wire wr_last = take && hwrite_in && haddr_in == 32'h14;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  property p_ok; hreadyout_out && !hresp_out; endproperty
  a_ok: assert property (p_ok) else $error("bus answer wrong");
  property p_rst; $fell(rst_in) |-> timer_five_level_out == 3'h4; endproperty
  a_rst: assert property (p_rst) else $error("reset level wrong");
  property p_pad; (hrdata_out & 32'hffff8888) == 32'h0; endproperty
  a_pad: assert property (p_pad) else $error("pad bits set");
  property p_en; source_enable_out[3] == |timer_three_level_out; endproperty
  a_en: assert property (p_en) else $error("enable wrong");
  // The write lands at the end of the data phase, a cycle after the take.
  property p_wr; take && hwrite_in && haddr_in == 32'h0 ##1 1'b1
    |=> serial1_rx_level_out == $past(hwdata_in[14:12])
    && timer_three_level_out == $past(hwdata_in[2:0]); endproperty
  a_wr: assert property (p_wr) else $error("write lost");
  property p_hold; !$past(wr_last, 2) && !$past(rst_in)
    |-> $stable(timer_five_level_out); endproperty
  a_hold: assert property (p_hold) else $error("level moved");
  property p_rd; take && !hwrite_in && haddr_in == 32'h0
    |=> hrdata_out[14:12] == $past(serial1_rx_level_out)
    && hrdata_out[2:0] == $past(timer_three_level_out); endproperty
  a_rd: assert property (p_rd) else $error("read wrong");
  property p_gap; take && !hwrite_in && haddr_in == 32'h18
    |=> hrdata_out == 32'h0; endproperty
  a_gap: assert property (p_gap) else $error("gap not zero");
endmodule

// ===== dv/ipr_regs_bench.sv
`timescale 1ns/1ps
module ipr_regs_bench;
  logic        clk = 1'b0, rst = 1'b1, sel = 1'b0, wr = 1'b0, rdy;
  logic [1:0]  trn = 2'h0;
  logic [31:0] adr = 32'h0, wd = 32'h0, rd, got;
  logic [2:0]  l2 [4];
  logic [21:0] en;
  int          n_errors = 0, checks_done = 0;
  logic [55:0] rows [8] = '{56'h00_4444_ffff_7777, 56'h04_0444_ffff_0777,
    56'h08_4044_ffff_7077, 56'h0c_4444_ffff_7777, 56'h10_4444_5a5a_5252,
    56'h14_4444_1234_1234, 56'h18_0000_ffff_0000, 56'h20_0000_ffff_0000};
  always #5 clk = ~clk;
  ipr_regs dut (.core_clk_in(clk), .rst_in(rst), .hsel_in(sel),
    .haddr_in(adr), .htrans_in(trn), .hwrite_in(wr), .hsize_in(3'h2),
    .hwdata_in(wd), .hready_in(rdy), .hrdata_out(rd), .hreadyout_out(rdy),
    .hresp_out(), .serial1_rx_level_out(l2[0]),
    .spi_one_event_level_out(l2[1]), .spi_one_error_level_out(l2[2]),
    .timer_three_level_out(l2[3]), .dma_ch1_done_level_out(),
    .adc_one_done_level_out(), .serial1_tx_level_out(),
    .change_notify_level_out(), .i2c_one_master_level_out(),
    .i2c_one_slave_level_out(), .capture_ch8_level_out(),
    .capture_ch7_level_out(), .adc_two_done_level_out(),
    .ext_irq1_level_out(), .timer_four_level_out(),
    .compare_ch4_level_out(), .compare_ch3_level_out(),
    .dma_ch2_done_level_out(), .serial2_tx_level_out(),
    .serial2_rx_level_out(), .ext_irq2_level_out(),
    .timer_five_level_out(), .source_enable_out(en));
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    checks_done++;
    if (seen !== want) begin
      n_errors++;
      $display("CHECK FAILED %0t: saw %h want %h", $time, seen, want);
    end
  endtask
  // The master never assumes a latency; only the watchdog ends a wait.
  task automatic xfer(input logic [31:0] a, d, input logic w);
    sel <= 1'b1;
    adr <= a;
    trn <= 2'h2;
    wr <= w;
    @(posedge clk);
    while (rdy !== 1'b1) @(posedge clk);
    sel <= 1'b0;
    trn <= 2'h0;
    wd <= d;
    @(posedge clk);
    while (rdy !== 1'b1) @(posedge clk);
    got = rd;
  endtask
  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    foreach (rows[i]) begin
      xfer({24'h0, rows[i][55:48]}, 32'h0, 1'b0);
      chk(got, {16'h0, rows[i][47:32]});
      xfer({24'h0, rows[i][55:48]}, {16'hffff, rows[i][31:16]}, 1'b1);
      xfer({24'h0, rows[i][55:48]}, 32'h0, 1'b0);
      chk(got, {16'h0, rows[i][15:0]});
    end
    xfer(32'h0, 32'h7100, 1'b1);
    @(negedge clk);
    chk({20'h0, l2[0], l2[1], l2[2], l2[3]}, 32'h0e40);
    chk({10'h0, en}, 32'h3ffff3);
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    xfer(32'h14, 32'h0, 1'b0);
    chk(got, 32'h4444);
    chk({10'h0, en}, 32'h3fffff);
    report_and_stop();
  end
  initial begin
    #20000 n_errors++;
    report_and_stop();
  end
endmodule
bind ipr_regs ipr_regs_checker u_checker (.*);
